// ==== core/dote_pkg.sv ====
`default_nettype none
package dote_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int DATA_W     = 8;
  localparam int NPFI       = 4;
  localparam int PFI_W      = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W      = 16;
  // ----------------------------------------
  // synchroniser lanes, terminals first
  // ----------------------------------------
  localparam int SY_AI_REF   = NPFI;
  localparam int SY_AI_START = NPFI + 1;
  localparam int SY_ANALOG   = NPFI + 2;
  localparam int SY_EXT_TB   = NPFI + 3;
  localparam int SY_EXT_UPD  = NPFI + 4;
  localparam int NSYNC       = NPFI + 5;
  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam logic [CNT_W-1:0]  CNT_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] DO_RST  = 8'h00;
  // ----------------------------------------
  // modes and selects
  // ----------------------------------------
  typedef enum logic [2:0] {ST_NONE, ST_SW_PULSE, ST_PFI, ST_AI_REF, ST_AI_START, ST_ANALOG} dote_start_src_t;
  typedef enum logic [1:0] {PS_NONE, PS_PFI, PS_ANALOG} dote_pause_src_t;
  typedef enum logic [1:0] {RG_REGEN, RG_ONBOARD, RG_NONREGEN} dote_regen_t;
  typedef enum logic [1:0] {RT_NONE, RT_UPD_CLK, RT_START} dote_route_t;
  typedef enum {S_IDLE, S_ARMED, S_DELAY, S_RUN} dote_fsm_t;

  typedef struct packed {
    logic                        hw_timed;
    logic                        finite;
    dote_regen_t                 regen;
    logic                        upd_ext;
    logic                        tb_ext;
    logic [CNT_W-1:0]            div;
    dote_start_src_t             start_src;
    logic                        start_fall;
    logic [PFI_W-1:0]            start_pfi;
    logic [CNT_W-1:0]            start_delay;
    dote_pause_src_t             pause_src;
    logic [PFI_W-1:0]            pause_pfi;
    logic                        pause_high;
    logic [CNT_W-1:0]            samples;
    dote_route_t [NPFI-1:0]      route;
    logic                        upd_inv;
  } dote_cfg_t;
endpackage
`default_nettype wire

// ==== core/dote_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module dote_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output var  logic         in_ready,
  output var  logic         out_valid,
  output var  logic [W-1:0] out_data,
  input  wire logic         out_ready,
  input  wire logic         recirc,
  input  wire logic         fill_en
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [CW-1:0]           cnt;
    logic                    rdy;
  } dote_fifo_st_t;

  dote_fifo_st_t q, d;
  logic          push;
  logic          pop;
  logic [W-1:0]  push_data;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    out_valid = (q.cnt != '0);
    out_data = q.mem[q.rd];
    pop = out_valid && out_ready;
    // replay mode pushes the popped word back behind the tail
    push = recirc ? pop : (in_valid && q.rdy && fill_en);
    push_data = recirc ? q.mem[q.rd] : in_data;
    if (push) begin
      d.mem[q.wr] = push_data;
      d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
    end
    if (pop) begin
      d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
    end
    d.cnt = q.cnt + CW'(push) - CW'(pop);
    d.rdy = fill_en && !recirc && (d.cnt != FULL);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready = q.rdy;
endmodule

module dote_top
  import dote_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire dote_pkg::dote_cfg_t         cfg,
  input  wire logic                        arm,
  input  wire logic                        sw_start,
  input  wire logic                        stop,
  input  wire logic                        sw_update,
  input  wire logic [dote_pkg::DATA_W-1:0] sw_data,
  input  wire logic [dote_pkg::NPFI-1:0]   pfi_in,
  input  wire logic                        ai_ref_trig,
  input  wire logic                        ai_start_trig,
  input  wire logic                        analog_cmp_evt,
  input  wire logic                        ext_timebase,
  input  wire logic                        ext_update_clk,
  input  wire logic                        host_valid,
  input  wire logic [dote_pkg::DATA_W-1:0] host_data,
  output var  logic                        host_ready,
  output var  logic [dote_pkg::DATA_W-1:0] do_data,
  output var  logic [dote_pkg::NPFI-1:0]   pfi_out,
  output var  logic [dote_pkg::NPFI-1:0]   pfi_oe,
  output var  logic                        armed,
  output var  logic                        running,
  output var  logic                        done,
  output var  logic                        underflow
);
  import dote_pkg::*;

  typedef struct packed {
    logic [NSYNC-1:0]  s1;
    logic [NSYNC-1:0]  s2;
    logic [NSYNC-1:0]  prev;
    dote_fsm_t         fsm;
    logic [CNT_W-1:0]  div_cnt;
    logic [CNT_W-1:0]  dly_cnt;
    logic [CNT_W-1:0]  smp_cnt;
    logic [DATA_W-1:0] dout;
    logic [NPFI-1:0]   pfi_o;
    logic [NPFI-1:0]   pfi_e;
    logic              armed;
    logic              run;
    logic              done;
    logic              unf;
  } dote_st_t;

  dote_st_t          q, d;
  logic [NSYNC-1:0]  async_v;
  logic              tb_tick;
  logic              ext_rise;
  logic              trig_hit;
  logic              pause_act;
  logic              upd_tick;
  logic              start_pulse;
  logic              fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic              fifo_pop;
  logic              recirc;
  logic              fill_en;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic edge_hit(input logic cur, input logic prv, input logic fall);
    edge_hit = fall ? (prv && !cur) : (cur && !prv);
  endfunction

  function automatic logic cnt_last(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
    cnt_last = ((cnt + CNT_ONE) >= lim);
  endfunction

  function automatic logic start_lvl(input logic [NSYNC-1:0] v, input dote_cfg_t c);
    case (c.start_src)
      ST_PFI:      start_lvl = v[c.start_pfi];
      ST_AI_REF:   start_lvl = v[SY_AI_REF];
      ST_AI_START: start_lvl = v[SY_AI_START];
      ST_ANALOG:   start_lvl = v[SY_ANALOG];
      default:     start_lvl = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // sample buffer
  // ----------------------------------------
  dote_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (host_valid),
    .in_data   (host_data),
    .in_ready  (host_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop),
    .recirc    (recirc),
    .fill_en   (fill_en)
  );

  assign async_v = {ext_update_clk, ext_timebase, analog_cmp_evt, ai_start_trig, ai_ref_trig, pfi_in};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.s1 = async_v;
    d.s2 = q.s1;
    d.prev = q.s2;
    upd_tick = 1'b0;
    start_pulse = 1'b0;
    fifo_pop = 1'b0;
    tb_tick = cfg.tb_ext ? edge_hit(q.s2[SY_EXT_TB], q.prev[SY_EXT_TB], 1'b0) : 1'b1;
    ext_rise = edge_hit(q.s2[SY_EXT_UPD], q.prev[SY_EXT_UPD], 1'b0);
    if (cfg.start_src == ST_NONE || cfg.start_src == ST_SW_PULSE) begin
      trig_hit = sw_start;
    end else begin
      trig_hit = edge_hit(start_lvl(q.s2, cfg), start_lvl(q.prev, cfg), cfg.start_fall);
    end
    case (cfg.pause_src)
      PS_PFI:    pause_act = (q.s2[cfg.pause_pfi] == cfg.pause_high);
      PS_ANALOG: pause_act = (q.s2[SY_ANALOG] == cfg.pause_high);
      default:   pause_act = 1'b0;
    endcase
    recirc = (cfg.regen == RG_ONBOARD) && (q.fsm == S_RUN || q.fsm == S_DELAY);
    fill_en = cfg.hw_timed && !recirc;

    case (q.fsm)
      S_IDLE: begin
        if (arm && cfg.hw_timed) begin
          d.fsm = S_ARMED;
          d.done = 1'b0;
          d.unf = 1'b0;
          d.smp_cnt = '0;
        end else if (!cfg.hw_timed && sw_update) begin
          d.dout = sw_data;
        end
      end
      S_ARMED: begin
        if (stop) begin
          d.fsm = S_IDLE;
        end else if (trig_hit) begin
          start_pulse = 1'b1;
          d.div_cnt = '0;
          d.dly_cnt = '0;
          if (!cfg.upd_ext && cfg.start_delay != '0) begin
            d.fsm = S_DELAY;
          end else begin
            d.fsm = S_RUN;
          end
        end
      end
      S_DELAY: begin
        if (stop) begin
          d.fsm = S_IDLE;
        end else if (tb_tick) begin
          d.dly_cnt = q.dly_cnt + CNT_ONE;
          if (cnt_last(q.dly_cnt, cfg.start_delay)) begin
            d.fsm = S_RUN;
          end
        end
      end
      S_RUN: begin
        if (!cfg.upd_ext) begin
          if (pause_act) begin
            d.div_cnt = '0;
          end else if (tb_tick) begin
            if (cnt_last(q.div_cnt, cfg.div)) begin
              upd_tick = 1'b1;
              d.div_cnt = '0;
            end else begin
              d.div_cnt = q.div_cnt + CNT_ONE;
            end
          end
        end else begin
          upd_tick = ext_rise && !pause_act;
        end
        if (stop) begin
          d.fsm = S_IDLE;
        end else if (upd_tick) begin
          if (fifo_valid) begin
            fifo_pop = 1'b1;
            d.dout = fifo_data;
            d.smp_cnt = q.smp_cnt + CNT_ONE;
            if (cfg.finite && cnt_last(q.smp_cnt, cfg.samples)) begin
              d.fsm = S_IDLE;
              d.done = 1'b1;
            end
          end else if (cfg.regen == RG_NONREGEN) begin
            d.unf = 1'b1;
          end
        end
      end
      default: begin
        d.fsm = S_IDLE;
      end
    endcase

    // terminal routing; the timebase has no route
    for (int i = 0; i < NPFI; i++) begin
      case (cfg.route[i])
        RT_UPD_CLK: begin
          d.pfi_o[i] = upd_tick ^ cfg.upd_inv;
          d.pfi_e[i] = 1'b1;
        end
        RT_START: begin
          d.pfi_o[i] = start_pulse;
          d.pfi_e[i] = 1'b1;
        end
        default: begin
          d.pfi_o[i] = 1'b0;
          d.pfi_e[i] = 1'b0;
        end
      endcase
    end
    d.armed = (d.fsm == S_ARMED);
    d.run = (d.fsm == S_RUN || d.fsm == S_DELAY);
  end

  // synchroniser keeps tracking the pins through reset, so a pin
  // that idles high gives no false edge after release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q      <= '0;
      q.s1   <= d.s1;
      q.s2   <= d.s2;
      q.prev <= d.prev;
    end else begin
      q <= d;
    end
  end

  assign do_data = q.dout;
  assign pfi_out = q.pfi_o;
  assign pfi_oe = q.pfi_e;
  assign armed = q.armed;
  assign running = q.run;
  assign done = q.done;
  assign underflow = q.unf;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_update_aligned: assert property (@(posedge clk) disable iff (!rst_n)
    fifo_pop |=> do_data == $past(fifo_data)) else $error("output word not taken on tick");
  chk_route_clk_high: assert property (@(posedge clk) disable iff (!rst_n)
    upd_tick && cfg.route[0] == RT_UPD_CLK && !cfg.upd_inv |=> pfi_out[0] && pfi_oe[0])
    else $error("routed update clock not high");
  chk_divider_gap: assert property (@(posedge clk) disable iff (!rst_n)
    upd_tick && !cfg.upd_ext && !cfg.tb_ext && cfg.div == 16'h0004 && $stable(cfg) |=> !upd_tick [*3])
    else $error("divided clock too fast");
  chk_no_tb_route: assert property (@(posedge clk) disable iff (!rst_n)
    pfi_out[0] && pfi_oe[0] |-> $past(upd_tick) || $past(start_pulse) || $past(cfg.upd_inv))
    else $error("terminal driven by other source");
  chk_sw_start: assert property (@(posedge clk) disable iff (!rst_n)
    q.fsm == S_ARMED && cfg.start_src == ST_NONE && sw_start && !stop |=> running)
    else $error("software start ignored");
  chk_delay_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    q.fsm == S_DELAY |-> !fifo_pop) else $error("sample during start delay");
  chk_start_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    start_pulse && cfg.route[1] == RT_START |=> pfi_out[1] ##1 !pfi_out[1] || $past(start_pulse))
    else $error("start pulse not driven");
  chk_pause_hold: assert property (@(posedge clk) disable iff (!rst_n)
    pause_act |-> !upd_tick) else $error("sample while paused");
  chk_ext_resume: assert property (@(posedge clk) disable iff (!rst_n)
    upd_tick && cfg.upd_ext |-> ext_rise && !pause_act) else $error("external resume without edge");
  chk_finite_stop: assert property (@(posedge clk) disable iff (!rst_n)
    fifo_pop && cfg.finite && !stop && q.smp_cnt + CNT_ONE == cfg.samples |=> done && !running)
    else $error("finite task did not stop");
  chk_replay_nofill: assert property (@(posedge clk) disable iff (!rst_n)
    recirc |=> !host_ready) else $error("host fill during onboard replay");
  chk_underflow_flag: assert property (@(posedge clk) disable iff (!rst_n)
    upd_tick && !fifo_valid && cfg.regen == RG_NONREGEN && !stop |=> underflow)
    else $error("underflow not flagged");
  chk_sw_update: assert property (@(posedge clk) disable iff (!rst_n)
    q.fsm == S_IDLE && !cfg.hw_timed && sw_update |=> do_data == $past(sw_data))
    else $error("software update lost");

  cov_finite_done: cover property (@(posedge clk) disable iff (!rst_n) running ##1 done);
  cov_underflow:   cover property (@(posedge clk) disable iff (!rst_n) $rose(underflow));
  cov_pause_run:   cover property (@(posedge clk) disable iff (!rst_n) running && pause_act ##1 !pause_act);
  cov_replay:      cover property (@(posedge clk) disable iff (!rst_n) recirc && fifo_pop);
endmodule
`default_nettype wire

// ==== tb/dote_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dote_host_model
  import dote_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        slow,
  input  wire logic                        host_ready,
  output var  logic                        host_valid,
  output var  logic [dote_pkg::DATA_W-1:0] host_data
);
  // ----------------------------------------
  // host buffer, handed over in order
  // ----------------------------------------
  logic [DATA_W-1:0] q[$];
  int                gap;
  always @(posedge clk) begin
    if (!rst_n) begin
      host_valid <= 1'b0;
      host_data  <= 8'h5a;
      gap        <= 0;
    end else if (host_valid && host_ready) begin
      void'(q.pop_front());
      host_valid <= !slow && q.size() != 0;
      host_data  <= (!slow && q.size() != 0) ? q[0] : ~host_data;
      gap        <= slow ? int'($urandom_range(3, 0)) : 0;
    end else if (!host_valid && (gap != 0 || q.size() == 0)) begin
      gap       <= (gap != 0) ? gap - 1 : 0;
      host_data <= ~host_data;
    end else if (!host_valid) begin
      host_valid <= 1'b1;
      host_data  <= q[0];
    end
  end
endmodule
`default_nettype wire

// ==== tb/dote_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module dote_top_tb;
  import dote_pkg::*;
  // ----------------------------------------
  // signals and monitors
  // ----------------------------------------
  localparam int CEIL = 20000;
  logic              clk = 1'b0, rst_n = 1'b0, arm = 1'b0, sw_start = 1'b0, stop = 1'b0, slow = 1'b0;
  logic              sw_update = 1'b0, ai_ref_trig = 1'b0, ai_start_trig = 1'b0, analog_cmp_evt = 1'b0;
  logic              ext_timebase = 1'b0, ext_update_clk = 1'b0, ph = 1'b0;
  logic              host_valid, host_ready, armed, running, done, underflow;
  logic [NPFI-1:0]   pfi_in = '0, pfi_out, pfi_oe;
  logic [DATA_W-1:0] sw_data = '0, host_data, do_data, w[16], upd_q[$];
  dote_cfg_t         cfg = '0;
  int                upd_t[$], lat[2], st_cnt, cyc_cnt, err_count, total_checks, n, t0, dly;

  dote_top dote_top_inst (
    .clk(clk), .rst_n(rst_n), .cfg(cfg), .arm(arm), .sw_start(sw_start), .stop(stop),
    .sw_update(sw_update), .sw_data(sw_data), .pfi_in(pfi_in), .ai_ref_trig(ai_ref_trig),
    .ai_start_trig(ai_start_trig), .analog_cmp_evt(analog_cmp_evt), .ext_timebase(ext_timebase),
    .ext_update_clk(ext_update_clk), .host_valid(host_valid), .host_data(host_data),
    .host_ready(host_ready), .do_data(do_data), .pfi_out(pfi_out), .pfi_oe(pfi_oe),
    .armed(armed), .running(running), .done(done), .underflow(underflow)
  );
  dote_host_model dote_host_model_inst (
    .clk(clk), .rst_n(rst_n), .slow(slow), .host_ready(host_ready), .host_valid(host_valid),
    .host_data(host_data)
  );

  always #20 clk = ~clk;

  // update pulses on terminal 0, start pulses on terminal 1
  always @(posedge clk) begin
    cyc_cnt++;
    if (pfi_out[0] === 1'b1) begin
      upd_q.push_back(do_data);
      upd_t.push_back(cyc_cnt);
    end
    if (pfi_out[1] === 1'b1) st_cnt++;
    if (cyc_cnt == CEIL) begin
      err_count++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic restart(dote_regen_t rg, int d);
    rst_n = 1'b0;
    cfg = '0;
    cfg.hw_timed = 1'b1;
    cfg.regen = rg;
    cfg.div = 16'(d);
    cfg.route[0] = RT_UPD_CLK;
    cfg.route[1] = RT_START;
    cyc(16);
    rst_n = 1'b1;
    upd_q.delete();
    upd_t.delete();
    st_cnt = 0;
    cyc(2);
  endtask
  task automatic load(int k);
    for (int i = 0; i < k; i++) begin
      w[i] = 8'($urandom);
      dote_host_model_inst.q.push_back(w[i]);
    end
    for (int i = 0; i < 100 && host_ready === 1'b1 && (dote_host_model_inst.q.size() != 0 || host_valid); i++) cyc(1);
  endtask
  task automatic go();
    arm = 1'b1;
    cyc(1);
    arm = 1'b0;
    sw_start = 1'b1;
    cyc(1);
    sw_start = 1'b0;
  endtask
  task automatic halt();
    stop = 1'b1;
    cyc(1);
    stop = 1'b0;
    cyc(2);
  endtask
  task automatic drive(int sel, logic v);
    case (sel)
      0: pfi_in[2] = v;
      1: ai_ref_trig = v;
      2: ai_start_trig = v;
      3: analog_cmp_evt = v;
      4: pfi_in[3] = v;
      5: ext_update_clk = v;
      default: ext_timebase = v;
    endcase
  endtask
  task automatic tick(int sel);
    drive(sel, 1'b1);
    cyc(5);
    drive(sel, 1'b0);
    cyc(5);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'hce38fdf1));
    restart(RG_REGEN, 2);
    check("flags", {armed, running, done, underflow, pfi_out}, 8'h00);
    check("pfi_oe", pfi_oe, 4'h3);
    cfg.hw_timed = 1'b0;
    for (int i = 0; i < 4; i++) begin
      sw_data = 8'($urandom);
      sw_update = 1'b1;
      cyc(1);
      sw_update = 1'b0;
      cyc(1);
      check("sw_do", do_data, sw_data);
    end
    check("sw_ready", {host_ready, 8'(upd_q.size())}, 9'h0);
    restart(RG_REGEN, 2 + $urandom_range(2, 0));
    cfg.finite = 1'b1;
    cfg.samples = 16'd12;
    cfg.start_src = ST_SW_PULSE;
    slow = 1'b1;
    load(12);
    check("full", host_ready, 1'b0);
    go();
    for (int i = 0; i < 600 && done !== 1'b1; i++) cyc(1);
    cyc(20);
    check("count", 16'(upd_q.size()), 16'd12);
    for (int i = 0; i < 12; i++) check("seq", upd_q[i], w[i]);
    check("end", {running, done, 8'(st_cnt)}, 10'h101);
    slow = 1'b0;
    dly = 1 + $urandom_range(5, 0);
    ph = 1'($urandom);
    for (int p = 0; p < 2; p++) begin
      drive(p ? 3 : 4, !ph);
      restart(RG_ONBOARD, 3);
      cfg.start_delay = p ? 16'(dly) : 16'h0;
      cfg.pause_src = p ? PS_ANALOG : PS_PFI;
      cfg.pause_pfi = 2'd3;
      cfg.pause_high = ph;
      load(3);
      t0 = cyc_cnt;
      go();
      for (int i = 0; i < 80 && upd_q.size() < 7; i++) cyc(1);
      lat[p] = upd_t[0] - t0;
      check("replay_ready", host_ready, 1'b0);
      for (int i = 0; i < 7; i++) check("replay", upd_q[i], w[i % 3]);
      for (int i = 1; i < 7; i++) check("period", 16'(upd_t[i] - upd_t[i-1]), 16'd3);
      drive(p ? 3 : 4, ph);
      cyc(6);
      n = upd_q.size();
      cyc(30);
      check("paused", 16'(upd_q.size()), 16'(n));
      drive(p ? 3 : 4, !ph);
      t0 = cyc_cnt;
      for (int i = 0; i < 30 && upd_q.size() <= n; i++) cyc(1);
      check("resume", 16'(upd_q.size() > n && upd_t[n] - t0 <= 10), 16'h1);
      halt();
    end
    check("delay", 16'(lat[1] - lat[0]), 16'(dly));
    for (int k = 0; k < 8; k++) begin
      drive(k / 2, !k[0]);
      restart(RG_REGEN, 2);
      cfg.start_src = dote_start_src_t'(3'(k / 2 + 2));
      cfg.start_fall = k[0];
      cfg.start_pfi = 2'd2;
      go();
      drive(k / 2, k[0]);
      cyc(8);
      check("wrong_edge", {running, armed}, 2'b01);
      drive(k / 2, !k[0]);
      for (int i = 0; i < 8 && running !== 1'b1; i++) cyc(1);
      cyc(3);
      check("trig", {running, 8'(st_cnt)}, 9'h101);
      halt();
    end
    drive(4, 1'b0);
    restart(RG_ONBOARD, 1);
    cfg.upd_ext = 1'b1;
    cfg.pause_src = PS_PFI;
    cfg.pause_pfi = 2'd3;
    cfg.pause_high = 1'b1;
    load(3);
    go();
    repeat (3) tick(5);
    drive(4, 1'b1);
    cyc(6);
    repeat (2) tick(5);
    drive(4, 1'b0);
    cyc(12);
    check("ext_wait", 16'(upd_q.size()), 16'h3);
    tick(5);
    check("ext_go", {8'(upd_q.size()), upd_q[3]}, {8'h4, w[0]});
    halt();
    restart(RG_ONBOARD, 2);
    cfg.tb_ext = 1'b1;
    load(3);
    go();
    repeat (6) tick(6);
    check("ext_tb", 16'(upd_q.size()), 16'h3);
    halt();
    restart(RG_NONREGEN, 2);
    load(2);
    go();
    cyc(30);
    check("underflow", {underflow, do_data}, {1'b1, w[1]});
    halt();
    go();
    check("arm_clr", {running, underflow}, 2'b10);
    give_verdict();
  end
endmodule
`default_nettype wire
